// ### shared/conv_seq_cfg.svh
// Constants of the conversion sequencer: register byte addresses, field positions,
// reset values and converter-clock gap counts. Included by bare name; definitions only.
`ifndef CONV_SEQ_CFG_SVH
`define CONV_SEQ_CFG_SVH
// Register byte addresses
`define OFF_CONV_STATUS 32'h40012400
`define OFF_CONTROL_ONE 32'h40012404
`define OFF_CONTROL_TWO 32'h40012408
`define OFF_SAMPLE_TIME_ONE 32'h4001240C
`define OFF_SAMPLE_TIME_TWO 32'h40012410
`define OFF_INJ_OFFSET_ONE 32'h40012414
`define OFF_INJ_OFFSET_TWO 32'h40012418
`define OFF_INJ_OFFSET_THREE 32'h4001241C
`define OFF_INJ_OFFSET_FOUR 32'h40012420
`define OFF_WATCH_HIGH_LIMIT 32'h40012424
`define OFF_WATCH_LOW_LIMIT 32'h40012428
`define OFF_REGULAR_SEQ_ONE 32'h4001242C
`define OFF_REGULAR_SEQ_TWO 32'h40012430
`define OFF_REGULAR_SEQ_THREE 32'h40012434
`define OFF_INJECTED_SEQ 32'h40012438
`define OFF_INJ_RESULT_ONE 32'h4001243C
`define OFF_INJ_RESULT_TWO 32'h40012440
`define OFF_INJ_RESULT_THREE 32'h40012444
`define OFF_INJ_RESULT_FOUR 32'h40012448
`define OFF_REGULAR_RESULT 32'h4001244C
`define OFF_CONTROL_THREE 32'h40012450
`define OFF_WATCH_LIMITS_ONE 32'h40012454
`define OFF_WATCH_LIMITS_TWO 32'h40012458
// Number of words in the register block
`define REG_WORDS 23
// Status flag positions
`define ST_WATCH 0
`define ST_END 1
`define ST_INJ_END 2
`define ST_INJ_STARTED 3
`define ST_REG_STARTED 4
// control_one fields
`define C1_WD_CHAN_LSB 0
`define C1_END_IRQ_EN 5
`define C1_WD_IRQ_EN 6
`define C1_INJ_END_IRQ_EN 7
`define C1_SCAN 8
`define C1_WD_SINGLE 9
`define C1_AUTO_INJ 10
`define C1_REG_DISC 11
`define C1_INJ_DISC 12
`define C1_SUBSEQ_LSB 13
`define C1_WD_INJ_EN 22
`define C1_WD_REG_EN 23
`define C1_WRITE_MASK 32'h07C0FFFF
// control_two fields
`define C2_POWER 0
`define C2_CONTINUOUS 1
`define C2_INJ_EXT_EN 15
`define C2_REG_EXT_EN 20
`define C2_INJ_SW_START 21
`define C2_REG_SW_START 22
`define C2_WRITE_MASK 32'h001EF93F
// Group length fields
`define RSEQ_LEN_LSB 20
`define ISEQ_LEN_LSB 20
// Reset values
`define RST_WATCH_HIGH 32'h00000FFF
`define RST_CONTROL_THREE 32'h00000001
`define RST_WATCH_LIMITS 32'h0FFF0000
// Converter clock prescaler code for divide-by-two and group-switch gaps in converter clocks
`define PRESC_DIV2 2'h0
`define GAP_TICKS_DIV2 2'h2
`define GAP_TICKS_OTHER 2'h1
`endif

// ### shared/conv_seq_pkg.sv
// Types shared by the conversion sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package conv_seq_pkg;
  // Sequencer state
  typedef enum logic [1:0] {st_idle = 2'b00, st_gap = 2'b01, st_busy = 2'b10} seq_state_e;
  // Channel group being converted
  typedef enum logic {grp_reg = 1'b0, grp_inj = 1'b1} group_e;
endpackage

// ### rtl/conv_clk_tick.sv
// Converter clock divider: one sys_clk pulse per converter clock period.
// Assumes the prescaler code is static while conversions run.
`timescale 1ns/10ps
`default_nettype none
module conv_clk_tick #(
  parameter int CNT_W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Prescaler code: divide by 2, 4, 6 or 8
  input wire logic [1:0] prescale,
  // Converter clock tick
  output logic tick
);
  // Period counter and its terminal value 2*code+1
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_w;

  assign last_w = CNT_W'({prescale, 1'b1});

  // Count the period and pulse at its end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (cnt_r >= last_w) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= CNT_W'(cnt_r + 1'b1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/conv_sequencer.sv
// Conversion sequencer: registers, group sequencing, flags and watchdog of a 12-bit converter.
// Assumes the analog core runs on sys_clk; trigger pins are asynchronous and are synchronised here.
// Notes on behaviour
// RQ1 - Single mode converts first group channel once
// RQ2 - Regular result stored, end flag, interrupt
// RQ3 - Injected result sets end and injected-end
// RQ4 - Scan walks whole group in order
// RQ5 - Injected trigger aborts regular, then resumes it
// RQ6 - Regular start waits for injected sequence
// RQ7 - Injected triggers spaced beyond sequence time
// RQ8 - Auto injection follows regular group end
// RQ9 - Software keeps injected trigger off in auto
// RQ10 - Group switch inserts one or two gaps
// RQ11 - Discontinuous trigger converts next n channels
// RQ12 - Never discontinuous on both groups together
// RQ13 - No discontinuous with auto or continuous
// RQ14 - Discontinuous flags only on last subsequence
// RQ15 - After last subsequence wait, restart at first
// RQ16 - Continuous restarts group until bit cleared
// RQ17 - Continuous injected results set injected-end
// RQ18 - Power bit starts regular; starts independent
// RQ19 - Watchdog flags values outside 12-bit limits
// RQ20 - Watchdog group enables and single channel
// RQ21 - Regular started flag set on regular start
// RQ22 - Flags cleared by writing zero; regular result read clears end
// RQ23 - Power rewrite starts only if nothing else
// RQ24 - Each group keeps its own sequence position
//
// Implementation choice: the address-and-strobe port.
`include "conv_seq_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module conv_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // Trigger inputs, rising edge starts
  input wire logic reg_trig_in,
  input wire logic inj_trig_in,
  // Converter clock prescaler code
  input wire logic [1:0] converter_clock_prescaler,
  // Analog core
  output logic conv_start,
  output logic conv_abort,
  output logic [4:0] conv_channel,
  output logic power_on,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // Interrupt request level
  output logic irq_request
);
  // Byte addresses of the registers
  localparam logic [31:0] A_STATUS = `OFF_CONV_STATUS;
  localparam logic [31:0] A_CTL1 = `OFF_CONTROL_ONE;
  localparam logic [31:0] A_CTL2 = `OFF_CONTROL_TWO;
  localparam logic [31:0] A_WHI = `OFF_WATCH_HIGH_LIMIT;
  localparam logic [31:0] A_WLO = `OFF_WATCH_LOW_LIMIT;
  localparam logic [31:0] A_RSQ1 = `OFF_REGULAR_SEQ_ONE;
  localparam logic [31:0] A_RSQ2 = `OFF_REGULAR_SEQ_TWO;
  localparam logic [31:0] A_RSQ3 = `OFF_REGULAR_SEQ_THREE;
  localparam logic [31:0] A_ISQ = `OFF_INJECTED_SEQ;
  localparam logic [31:0] A_IRES1 = `OFF_INJ_RESULT_ONE;
  localparam logic [31:0] A_IRES4 = `OFF_INJ_RESULT_FOUR;
  localparam logic [31:0] A_RRES = `OFF_REGULAR_RESULT;
  localparam logic [31:0] A_CTL3 = `OFF_CONTROL_THREE;
  localparam logic [31:0] A_WL1 = `OFF_WATCH_LIMITS_ONE;
  localparam logic [31:0] A_WL2 = `OFF_WATCH_LIMITS_TWO;

  // Register storage, results and flags
  logic [31:0] cfg_r [0:`REG_WORDS-1];
  logic [15:0] reg_res_r;
  logic [15:0] inj_res_r [0:3];
  logic [4:0] flags_r;
  // Sequencer state
  conv_seq_pkg::seq_state_e state_r;
  conv_seq_pkg::group_e grp_r;
  logic [3:0] reg_pos_r;
  logic [1:0] inj_pos_r;
  logic [2:0] sub_cnt_r;
  logic reg_pend_r;
  logic inj_pend_r;
  logic chained_r;
  logic [1:0] gap_r;
  // Trigger synchronisers, third stage for edge detection
  logic [2:0] reg_sync_r;
  logic [2:0] inj_sync_r;
  // Decode
  logic [4:0] idx_w;
  logic in_block_w;
  logic writable_w;
  logic wr_ctl2_w;
  // Control fields
  logic [31:0] ctl1_w;
  logic [31:0] ctl2_w;
  logic power_w;
  logic continuous_mode_bit_w;
  logic scan_w;
  logic auto_injection_enable_w;
  logic rdisc_w;
  logic idisc_w;
  logic [2:0] subseq_w;
  logic [3:0] reg_lastidx_w;
  logic [1:0] inj_lastidx_w;
  logic [79:0] reg_flat_w;
  logic [6:0] reg_bit_w;
  logic [4:0] inj_bit_w;
  logic [4:0] reg_chan_w;
  logic [4:0] inj_chan_w;
  // Events and sequence ends
  logic rewrite_w;
  logic reg_evt_w;
  logic inj_evt_w;
  logic tick_w;
  logic [1:0] gap_ticks_w;
  logic done_w;
  logic reg_last_w;
  logic inj_last_w;
  logic sub_last_w;
  logic wd_hit_w;
  logic [4:0] keep_w;
  logic [4:0] set_w;

  // Converter clock tick source
  conv_clk_tick #(.CNT_W(3)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .prescale(converter_clock_prescaler),
    .tick(tick_w)
  );

  // Address decode
  assign idx_w = addr[6:2];
  assign in_block_w = (addr[31:7] == A_STATUS[31:7]) && (addr[1:0] == 2'h0) && (idx_w <= A_WL2[6:2]);
  assign writable_w = ((idx_w >= A_CTL1[6:2]) && (idx_w <= A_ISQ[6:2])) || (idx_w >= A_CTL3[6:2]);
  assign wr_ctl2_w = wr_stb && in_block_w && (idx_w == A_CTL2[6:2]);

  // Control fields
  assign ctl1_w = cfg_r[A_CTL1[6:2]];
  assign ctl2_w = cfg_r[A_CTL2[6:2]];
  assign power_w = ctl2_w[`C2_POWER];
  assign continuous_mode_bit_w = ctl2_w[`C2_CONTINUOUS];
  assign scan_w = ctl1_w[`C1_SCAN];
  assign auto_injection_enable_w = ctl1_w[`C1_AUTO_INJ];
  assign rdisc_w = ctl1_w[`C1_REG_DISC];
  assign idisc_w = ctl1_w[`C1_INJ_DISC];
  assign subseq_w = ctl1_w[`C1_SUBSEQ_LSB +: 3];
  // Single mode converts the first channel only
  assign reg_lastidx_w = (scan_w || rdisc_w) ? cfg_r[A_RSQ1[6:2]][`RSEQ_LEN_LSB +: 4] : 4'h0; // RQ1
  assign inj_lastidx_w = (scan_w || idisc_w) ? cfg_r[A_ISQ[6:2]][`ISEQ_LEN_LSB +: 2] : 2'h0; // RQ1
  // Channel lists, position 0 in the low bits
  assign reg_flat_w = {cfg_r[A_RSQ1[6:2]][19:0], cfg_r[A_RSQ2[6:2]][29:0], cfg_r[A_RSQ3[6:2]][29:0]};
  assign reg_bit_w = 7'(reg_pos_r) * 7'h5;
  assign inj_bit_w = 5'(inj_pos_r) * 5'h5;
  assign reg_chan_w = reg_flat_w[reg_bit_w +: 5];
  assign inj_chan_w = cfg_r[A_ISQ[6:2]][inj_bit_w +: 5];

  // Start events: power rewrite with nothing else changed, software bits, trigger edges
  assign rewrite_w = wr_ctl2_w && power_w && wdata[`C2_POWER]
    && (((wdata & `C2_WRITE_MASK) ^ ctl2_w) == 32'h0); // RQ23
  assign reg_evt_w = power_w && (rewrite_w || (wr_ctl2_w && wdata[`C2_REG_SW_START])
    || (ctl2_w[`C2_REG_EXT_EN] && reg_sync_r[1] && !reg_sync_r[2])); // RQ18
  assign inj_evt_w = power_w && ((wr_ctl2_w && wdata[`C2_INJ_SW_START])
    || (ctl2_w[`C2_INJ_EXT_EN] && inj_sync_r[1] && !inj_sync_r[2])); // RQ18

  // Sequence end conditions
  assign gap_ticks_w = (converter_clock_prescaler == `PRESC_DIV2) ? `GAP_TICKS_DIV2 : `GAP_TICKS_OTHER;
  // A result arriving in the cycle of an injected preemption is dropped with the aborted conversion
  assign done_w = (state_r == conv_seq_pkg::st_busy) && conv_done && power_w
    && !(grp_r == conv_seq_pkg::grp_reg && inj_pend_r && !auto_injection_enable_w); // RQ5
  assign reg_last_w = (reg_pos_r >= reg_lastidx_w);
  assign inj_last_w = (inj_pos_r >= inj_lastidx_w);
  assign sub_last_w = (sub_cnt_r == subseq_w);

  // Watchdog: group enable, optional single channel, outside limits
  assign wd_hit_w = done_w
    && (grp_r == conv_seq_pkg::grp_reg ? ctl1_w[`C1_WD_REG_EN] : ctl1_w[`C1_WD_INJ_EN]) // RQ20
    && (!ctl1_w[`C1_WD_SINGLE] || conv_channel == ctl1_w[`C1_WD_CHAN_LSB +: 5]) // RQ20
    && ((conv_result < cfg_r[A_WLO[6:2]][11:0]) || (conv_result > cfg_r[A_WHI[6:2]][11:0])); // RQ19

  // Trigger synchronisers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_sync_r <= 3'h0;
      inj_sync_r <= 3'h0;
    end else begin
      reg_sync_r <= {reg_sync_r[1:0], reg_trig_in};
      inj_sync_r <= {inj_sync_r[1:0], inj_trig_in};
    end
  end

  // Register file writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `REG_WORDS; i++) begin
        cfg_r[i] <= 32'h0;
      end
      cfg_r[A_WHI[6:2]] <= `RST_WATCH_HIGH;
      cfg_r[A_CTL3[6:2]] <= `RST_CONTROL_THREE;
      cfg_r[A_WL1[6:2]] <= `RST_WATCH_LIMITS;
      cfg_r[A_WL2[6:2]] <= `RST_WATCH_LIMITS;
    end else if (wr_stb && in_block_w && writable_w) begin
      if (idx_w == A_CTL1[6:2]) begin
        cfg_r[idx_w] <= wdata & `C1_WRITE_MASK;
      end else if (idx_w == A_CTL2[6:2]) begin
        cfg_r[idx_w] <= wdata & `C2_WRITE_MASK;
      end else begin
        cfg_r[idx_w] <= wdata;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata <= 32'h0;
    end else if (rd_stb && in_block_w) begin
      if (idx_w == A_STATUS[6:2]) begin
        rdata <= {27'h0, flags_r};
      end else if (idx_w == A_RRES[6:2]) begin
        rdata <= {16'h0, reg_res_r};
      end else if (idx_w >= A_IRES1[6:2] && idx_w <= A_IRES4[6:2]) begin
        rdata <= {16'h0, inj_res_r[2'(idx_w - A_IRES1[6:2])]};
      end else begin
        rdata <= cfg_r[idx_w];
      end
    end else begin
      rdata <= 32'h0;
    end
  end

  // Sequencer: dispatch, gap, conversion, preemption
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= conv_seq_pkg::st_idle;
      grp_r <= conv_seq_pkg::grp_reg;
      reg_pos_r <= 4'h0;
      inj_pos_r <= 2'h0;
      sub_cnt_r <= 3'h0;
      reg_pend_r <= 1'b0;
      inj_pend_r <= 1'b0;
      chained_r <= 1'b0;
      gap_r <= 2'h0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_channel <= 5'h0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      if (!power_w) begin
        // Power down ends all work
        conv_abort <= (state_r == conv_seq_pkg::st_busy);
        state_r <= conv_seq_pkg::st_idle;
        reg_pos_r <= 4'h0;
        inj_pos_r <= 2'h0;
        sub_cnt_r <= 3'h0;
        reg_pend_r <= 1'b0;
        inj_pend_r <= 1'b0;
        chained_r <= 1'b0;
      end else begin
        case (state_r)
          conv_seq_pkg::st_idle: begin
            if (inj_pend_r || reg_pend_r) begin
              // Injected work goes first; regular waits for it
              grp_r <= inj_pend_r ? conv_seq_pkg::grp_inj : conv_seq_pkg::grp_reg; // RQ6
              if (chained_r && ((inj_pend_r ? conv_seq_pkg::grp_inj : conv_seq_pkg::grp_reg) != grp_r)) begin
                state_r <= conv_seq_pkg::st_gap; // RQ10
                gap_r <= gap_ticks_w; // RQ10
              end else begin
                state_r <= conv_seq_pkg::st_busy;
                conv_start <= 1'b1;
                conv_channel <= inj_pend_r ? inj_chan_w : reg_chan_w; // RQ24
              end
            end else begin
              chained_r <= 1'b0;
            end
          end
          conv_seq_pkg::st_gap: begin
            // Count converter clocks before switching group
            if (tick_w) begin
              if (gap_r <= 2'h1) begin
                state_r <= conv_seq_pkg::st_busy;
                conv_start <= 1'b1;
                conv_channel <= (grp_r == conv_seq_pkg::grp_inj) ? inj_chan_w : reg_chan_w;
              end else begin
                gap_r <= 2'(gap_r - 2'h1);
              end
            end
          end
          conv_seq_pkg::st_busy: begin
            if (grp_r == conv_seq_pkg::grp_reg && inj_pend_r && !auto_injection_enable_w) begin
              // Injection resets the regular conversion; position is kept for resume
              conv_abort <= 1'b1; // RQ5
              state_r <= conv_seq_pkg::st_idle; // RQ5
              chained_r <= 1'b1;
            end else if (conv_done) begin
              state_r <= conv_seq_pkg::st_idle;
              chained_r <= 1'b1;
              if (grp_r == conv_seq_pkg::grp_reg) begin
                if (reg_last_w) begin
                  // Group done: wrap, continue or hand over to injection
                  reg_pos_r <= 4'h0; // RQ16
                  // Subsequence count belongs to the discontinuous group only
                  sub_cnt_r <= idisc_w ? sub_cnt_r : 3'h0; // RQ15
                  reg_pend_r <= continuous_mode_bit_w && !auto_injection_enable_w; // RQ16
                  if (auto_injection_enable_w) begin
                    inj_pend_r <= 1'b1; // RQ8
                  end
                end else if (rdisc_w && sub_last_w) begin
                  // Subsequence done, wait for next trigger
                  reg_pos_r <= 4'(reg_pos_r + 4'h1); // RQ11
                  sub_cnt_r <= 3'h0; // RQ11
                  reg_pend_r <= 1'b0; // RQ11
                end else begin
                  reg_pos_r <= 4'(reg_pos_r + 4'h1); // RQ4
                  sub_cnt_r <= idisc_w ? sub_cnt_r : 3'(sub_cnt_r + 3'h1); // RQ24
                end
              end else begin
                if (inj_last_w) begin
                  inj_pos_r <= 2'h0; // RQ16
                  sub_cnt_r <= rdisc_w ? sub_cnt_r : 3'h0; // RQ15
                  inj_pend_r <= continuous_mode_bit_w && !auto_injection_enable_w; // RQ16
                  if (continuous_mode_bit_w && auto_injection_enable_w) begin
                    reg_pend_r <= 1'b1; // RQ16
                  end
                end else if (idisc_w && sub_last_w) begin
                  inj_pos_r <= 2'(inj_pos_r + 2'h1); // RQ11
                  sub_cnt_r <= 3'h0;
                  inj_pend_r <= 1'b0; // RQ11
                end else begin
                  inj_pos_r <= 2'(inj_pos_r + 2'h1); // RQ4
                  sub_cnt_r <= rdisc_w ? sub_cnt_r : 3'(sub_cnt_r + 3'h1); // RQ24
                end
              end
            end
          end
          default: begin
            state_r <= conv_seq_pkg::st_idle;
          end
        endcase
        // New start events win over clears in the same cycle
        if (reg_evt_w) begin
          reg_pend_r <= 1'b1; // RQ18
        end
        if (inj_evt_w) begin
          inj_pend_r <= 1'b1; // RQ18
        end
      end
    end
  end

  // Flag set terms and software clears
  always_comb begin
    set_w = 5'h0;
    set_w[`ST_WATCH] = wd_hit_w; // RQ19
    set_w[`ST_END] = done_w && ((grp_r == conv_seq_pkg::grp_reg) ? (!rdisc_w || reg_last_w) : inj_last_w); // RQ14
    set_w[`ST_INJ_END] = done_w && (grp_r == conv_seq_pkg::grp_inj) && (inj_last_w || continuous_mode_bit_w); // RQ17
    set_w[`ST_INJ_STARTED] = conv_start && (grp_r == conv_seq_pkg::grp_inj);
    set_w[`ST_REG_STARTED] = conv_start && (grp_r == conv_seq_pkg::grp_reg); // RQ21
    keep_w = (wr_stb && in_block_w && idx_w == A_STATUS[6:2]) ? wdata[4:0] : 5'h1F; // RQ22
    if (rd_stb && in_block_w && idx_w == A_RRES[6:2]) begin
      keep_w[`ST_END] = 1'b0; // RQ22
    end
  end

  // Flags, results and interrupt request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_r <= 5'h0;
      reg_res_r <= 16'h0;
      for (int i = 0; i < 4; i++) begin
        inj_res_r[i] <= 16'h0;
      end
      irq_request <= 1'b0;
      power_on <= 1'b0;
    end else begin
      flags_r <= (flags_r & keep_w) | set_w; // RQ22
      if (done_w && grp_r == conv_seq_pkg::grp_reg) begin
        reg_res_r <= {4'h0, conv_result}; // RQ2
      end
      if (done_w && grp_r == conv_seq_pkg::grp_inj) begin
        inj_res_r[inj_pos_r] <= {4'h0, conv_result}; // RQ3
      end
      irq_request <= (flags_r[`ST_END] && ctl1_w[`C1_END_IRQ_EN])
        || (flags_r[`ST_INJ_END] && ctl1_w[`C1_INJ_END_IRQ_EN])
        || (flags_r[`ST_WATCH] && ctl1_w[`C1_WD_IRQ_EN]); // RQ2
      power_on <= power_w;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_reg_end_flag: assert property ( // RQ2
    (done_w && grp_r == conv_seq_pkg::grp_reg && !rdisc_w) |=> flags_r[`ST_END])
    else $error("regular conversion end did not set end flag");
  chk_inj_end_flags: assert property ( // RQ3
    (done_w && grp_r == conv_seq_pkg::grp_inj && inj_last_w) |=> (flags_r[`ST_END] && flags_r[`ST_INJ_END]))
    else $error("injected group end did not set both flags");
  chk_inj_preempt: assert property ( // RQ5
    (power_w && state_r == conv_seq_pkg::st_busy && grp_r == conv_seq_pkg::grp_reg && inj_pend_r && !auto_injection_enable_w)
    |=> (conv_abort && state_r == conv_seq_pkg::st_idle))
    else $error("injected request did not abort regular conversion");
  chk_inj_not_broken: assert property ( // RQ6
    (state_r == conv_seq_pkg::st_busy && grp_r == conv_seq_pkg::grp_inj && power_w) |=> !conv_abort)
    else $error("injected conversion was aborted");
  chk_gap_switch: assert property ( // RQ10
    (power_w && state_r == conv_seq_pkg::st_idle && chained_r && inj_pend_r && grp_r == conv_seq_pkg::grp_reg)
    |=> (state_r == conv_seq_pkg::st_gap && gap_r == $past(gap_ticks_w)))
    else $error("group switch skipped the gap");
  chk_disc_stop: assert property ( // RQ15
    (done_w && grp_r == conv_seq_pkg::grp_reg && rdisc_w && sub_last_w && !reg_evt_w) |=> !reg_pend_r)
    else $error("discontinuous subsequence did not stop");
  chk_watch_flag: assert property ( // RQ19
    wd_hit_w |=> flags_r[`ST_WATCH])
    else $error("watchdog hit did not set flag");
  chk_started_flag: assert property ( // RQ21
    (conv_start && grp_r == conv_seq_pkg::grp_reg) |=> flags_r[`ST_REG_STARTED])
    else $error("regular start did not set started flag");
  chk_one_ignored: assert property ( // RQ22
    (!flags_r[`ST_WATCH] && !wd_hit_w) |=> !flags_r[`ST_WATCH])
    else $error("watchdog flag set without a hit");
  chk_pos_kept: assert property ( // RQ24
    conv_abort && power_w |-> reg_pos_r == $past(reg_pos_r))
    else $error("abort moved the regular position");
endmodule
`default_nettype wire

// ### tb/analog_core_model.sv
// Behavioural model of the analog conversion core facing the sequencer.
// Assumes conv_start and conv_abort are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module analog_core_model (
  // Clock
  input wire logic sys_clk,
  // Sequencer side
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [4:0] conv_channel,
  input wire logic power_on,
  // Pace select, high gives a long conversion
  input wire logic slow,
  // Result side
  output logic conv_done,
  output logic [11:0] conv_result
);
  int cnt = 0; // Cycles left in the running conversion
  logic [4:0] ch_r = 5'h00; // Channel being converted
  initial begin
    conv_done = 1'b0;
    conv_result = 12'h000;
  end
  // One result per start; abort or power loss drops the conversion
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Result bus is meaningless between results, so keep it moving
    conv_result <= ~conv_result;
    if (conv_start) begin
      cnt <= slow ? 30 : 3;
      ch_r <= conv_channel;
    end else if (conv_abort || !power_on) begin
      cnt <= 0;
    end else if (cnt == 1) begin
      conv_done <= 1'b1;
      conv_result <= 12'h0A0 + 12'(ch_r);
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/adc_conversion_sequencer_tb_top.sv
// Self-checking bench of the conversion sequencer over its register port.
// Assumes the analog core model and the shared constants header.
`include "conv_seq_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
  logic sys_clk, reset, wr_stb, rd_stb, inj_trig_in, slow, conv_start, conv_abort, power_on, conv_done, irq_request;
  logic [31:0] addr, wdata, rdata, d;
  logic [4:0] conv_channel;
  logic [11:0] conv_result;
  logic [24:0] hist; // Channels of the last five starts
  logic reg_trig_in; // Regular trigger pin
  int bad_count, cmp_count, nstart, ndone, s0, d0;
  conv_sequencer i_conv_sequencer (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .reg_trig_in(reg_trig_in), .inj_trig_in(inj_trig_in),
    .converter_clock_prescaler(2'h0), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .power_on(power_on),
    .conv_done(conv_done), .conv_result(conv_result), .irq_request(irq_request));
  analog_core_model i_analog_core_model (.sys_clk(sys_clk), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .power_on(power_on), .slow(slow), .conv_done(conv_done), .conv_result(conv_result));
  // Clock of 10 ns
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Log of starts and results seen at the core
  always @(posedge sys_clk) begin
    if (conv_start) begin
      hist <= {hist[19:0], conv_channel};
      nstart <= nstart + 1;
    end
    if (conv_done) ndone <= ndone + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic ck(input logic [31:0] a, input logic [31:0] exp);
    rd(a, d);
    check(d, exp);
  endtask
  // Bounded wait until a counter reaches a value
  task automatic wait_cnt(ref int c, input int n);
    for (int k = 0; k < 2000 && c < n; k++) @(posedge sys_clk);
    if (c < n) bad_count++;
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end
  initial begin
    {reset, wr_stb, rd_stb, reg_trig_in, inj_trig_in, slow, addr, wdata, hist, nstart, ndone, bad_count, cmp_count} = '0;
    reset = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values, unmapped and read-only places
    ck(`OFF_WATCH_HIGH_LIMIT, `RST_WATCH_HIGH);
    ck(`OFF_CONTROL_THREE, `RST_CONTROL_THREE);
    ck(`OFF_WATCH_LIMITS_TWO, `RST_WATCH_LIMITS);
    wr(`OFF_REGULAR_RESULT, 32'h0000FFFF);
    ck(`OFF_REGULAR_RESULT, 32'h00000000);
    ck(32'h4001245C, 32'h00000000);
    $display("test registers done");
    // Power-up write alone, then single conversion of channel 3
    wr(`OFF_REGULAR_SEQ_THREE, 32'h00000003);
    wr(`OFF_CONTROL_ONE, 32'h00000020);
    wr(`OFF_CONTROL_TWO, 32'h00000001);
    ck(`OFF_CONV_STATUS, 32'h00000000);
    wr(`OFF_CONTROL_TWO, 32'h00000001);
    wait_cnt(ndone, 1);
    repeat (3) @(posedge sys_clk);
    ck(`OFF_CONV_STATUS, 32'h00000012);
    check(32'(irq_request), 32'h1);
    ck(`OFF_REGULAR_RESULT, 32'h000000A3);
    ck(`OFF_CONV_STATUS, 32'h00000010);
    wr(`OFF_CONV_STATUS, 32'h00000000);
    wr(`OFF_CONTROL_TWO, 32'h00000003);
    wr(`OFF_CONTROL_TWO, 32'h00000001);
    repeat (20) @(posedge sys_clk);
    ck(`OFF_CONV_STATUS, 32'h00000000);
    $display("test single done");
    // Regular scan 2,5,9 preempted by injected channel 7 during channel 5
    slow <= 1'b1;
    wr(`OFF_REGULAR_SEQ_ONE, 32'h00200000);
    wr(`OFF_REGULAR_SEQ_THREE, 32'h000024A2);
    wr(`OFF_INJECTED_SEQ, 32'h00000007);
    wr(`OFF_CONTROL_ONE, 32'h00000100);
    wr(`OFF_CONTROL_TWO, 32'h00008001);
    s0 = nstart;
    d0 = ndone;
    wr(`OFF_CONTROL_TWO, 32'h00008001);
    wait_cnt(nstart, s0 + 2);
    repeat (4) @(posedge sys_clk);
    inj_trig_in <= 1'b1;
    repeat (5) @(posedge sys_clk);
    inj_trig_in <= 1'b0;
    wait_cnt(ndone, d0 + 4);
    repeat (4) @(posedge sys_clk);
    check(hist, {5'd2, 5'd5, 5'd7, 5'd5, 5'd9});
    ck(`OFF_CONV_STATUS, 32'h0000001E);
    ck(`OFF_INJ_RESULT_ONE, 32'h000000A7);
    ck(`OFF_REGULAR_RESULT, 32'h000000A9);
    $display("test injection done");
    // Watchdog on regular channel above the high limit
    slow <= 1'b0;
    wr(`OFF_CONTROL_TWO, 32'h00000001);
    wr(`OFF_REGULAR_SEQ_ONE, 32'h00000000);
    wr(`OFF_REGULAR_SEQ_THREE, 32'h00000003);
    wr(`OFF_CONTROL_ONE, 32'h00800040);
    wr(`OFF_WATCH_HIGH_LIMIT, 32'h000000A0);
    wr(`OFF_CONV_STATUS, 32'h00000000);
    d0 = ndone;
    wr(`OFF_CONTROL_TWO, 32'h00000001);
    wait_cnt(ndone, d0 + 1);
    repeat (3) @(posedge sys_clk);
    ck(`OFF_CONV_STATUS, 32'h00000013);
    check(32'(irq_request), 32'h1);
    $display("test watchdog done");
    // Regular discontinuous scan of 1,3,2 in pairs, started by pin edges
    wr(`OFF_REGULAR_SEQ_ONE, 32'h00200000);
    wr(`OFF_REGULAR_SEQ_THREE, 32'h00000861);
    wr(`OFF_CONTROL_ONE, 32'h00002800);
    wr(`OFF_CONTROL_TWO, 32'h00100001);
    for (int t = 0; t < 3; t++) begin
      wr(`OFF_CONV_STATUS, 32'h00000000);
      d0 = ndone;
      reg_trig_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reg_trig_in <= 1'b0;
      wait_cnt(ndone, d0 + ((t == 1) ? 1 : 2));
      repeat (20) @(posedge sys_clk);
      check(ndone - d0, (t == 1) ? 1 : 2);
      ck(`OFF_CONV_STATUS, (t == 1) ? 32'h00000012 : 32'h00000010);
    end
    check(hist, {5'd1, 5'd3, 5'd2, 5'd1, 5'd3});
    $display("test discontinuous done");
    conclude();
  end
endmodule
`default_nettype wire
